// [shared/synth_ctrl_pkg.sv]
// Constants and carrier types for the synthesizer top-level control registers
package synth_ctrl_pkg;

	// Serial frame layout: one direction bit, seven address bits, sixteen data bits
	localparam int unsigned FRAME_BITS = 24;
	localparam int unsigned ADDR_W = 7;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned HEAD_BITS = 8;
	localparam logic [4:0] FRAME_BITS_C = 5'h18;
	localparam logic [4:0] HEAD_BITS_C = 5'h08;

	// Register offsets
	localparam logic [6:0] ADDR_MAIN_CTRL = 7'h00;
	localparam logic [6:0] ADDR_CAL_CLK = 7'h01;
	localparam logic [6:0] ADDR_RSVD_TWO = 7'h02;
	localparam logic [6:0] ADDR_ACAL_TIMING = 7'h04;
	localparam logic [6:0] ADDR_RSVD_SEVEN = 7'h07;

	// Field positions
	localparam int unsigned BIT_POWERDOWN = 0;
	localparam int unsigned BIT_RESET_CMD = 1;
	localparam int unsigned BIT_MUXOUT_SEL = 2;
	localparam int unsigned BIT_LD_EN = 13;
	localparam int unsigned CAL_DIV_LSB = 0;
	localparam int unsigned CAL_DIV_W = 3;
	localparam int unsigned SETTLE_LSB = 8;
	localparam int unsigned SETTLE_W = 8;

	// Reset values of the whole words (field defaults, reserved bits at the map pattern)
	localparam logic [15:0] RST_MAIN_CTRL = 16'h201c;
	localparam logic [15:0] RST_CAL_CLK = 16'h0003;
	localparam logic [15:0] RST_RSVD_TWO = 16'h0000;
	localparam logic [15:0] RST_ACAL_TIMING = 16'h1900;
	localparam logic [15:0] RST_RSVD_SEVEN = 16'h0000;

	// Decoded configuration handed to the analog and calibration logic
	typedef struct packed {
		logic powerdown;
		logic muxout_sel;
		logic lock_detect_en;
		logic [2:0] cal_clk_div;
		logic [7:0] amplitude_cal_settle_delay;
	} ctrl_cfg_s;

	// One decoded serial frame
	typedef struct packed {
		logic rd;
		logic [6:0] addr;
		logic [15:0] data;
	} frame_s;

endpackage : synth_ctrl_pkg

// [design/serial_frame_rx.sv]
// Serial interface receiver: pin synchronisers, bit shifter and frame framing
`timescale 1ns/10ps
module serial_frame_rx
	import synth_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// Serial pins
	input wire logic sclk_i,
	input wire logic sdi_i,
	input wire logic cs_n_i,
	// Decoded frame
	output frame_s frame_o,
	output logic head_valid_o,
	output logic frame_done_o,
	output logic sclk_fall_o
);

	localparam int unsigned NPIN = 3;

	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] filt_q;
	logic [NPIN-1:0] s1_q;
	logic [NPIN-1:0] s2_q;
	logic [NPIN-1:0] s3_q;
	logic [NPIN-1:0] agree;
	logic [NPIN-1:0] rise;
	logic [NPIN-1:0] fall;
	logic [23:0] shift_q;
	logic [4:0] count_q;
	logic head_q;
	logic done_q;

	assign pin_raw = {cs_n_i, sdi_i, sclk_i};

	// Three-stage synchroniser per pin; a change is taken once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < NPIN; g++)
		begin : g_sync
			always_ff @(posedge sys_clk_i or negedge nrst_i)
			begin
				if (!nrst_i)
				begin
					// Select stages start at its idle high level so no false edge follows reset
					s1_q[g] <= (g == 2) ? 1'b1 : 1'b0;
					s2_q[g] <= (g == 2) ? 1'b1 : 1'b0;
					s3_q[g] <= (g == 2) ? 1'b1 : 1'b0;
					filt_q[g] <= (g == 2) ? 1'b1 : 1'b0;
				end
				else
				begin
					s1_q[g] <= pin_raw[g];
					s2_q[g] <= s1_q[g];
					s3_q[g] <= s2_q[g];
					if (agree[g])
						filt_q[g] <= s3_q[g];
				end
			end
			assign agree[g] = (s2_q[g] == s3_q[g]);
			assign rise[g] = agree[g] & s3_q[g] & ~filt_q[g];
			assign fall[g] = agree[g] & ~s3_q[g] & filt_q[g];
		end
	endgenerate

	// Bits are taken MSB first on sclk rising while the select is low
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			shift_q <= 24'h000000;
			count_q <= 5'h00;
		end
		else if (filt_q[2] || fall[2])
		begin
			count_q <= 5'h00;
		end
		else if (rise[0] && count_q != FRAME_BITS_C)
		begin
			shift_q <= {shift_q[22:0], filt_q[1] | rise[1]};
			count_q <= count_q + 5'h01;
		end
	end

	// Header pulse once direction and address are in; frame pulse on select release
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			head_q <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			head_q <= rise[0] && !filt_q[2] && count_q == HEAD_BITS_C - 5'h01;
			done_q <= rise[2] && count_q == FRAME_BITS_C;
		end
	end

	assign frame_o = (count_q == HEAD_BITS_C) ? frame_s'({shift_q[7:0], 16'h0000}) : frame_s'(shift_q);
	assign head_valid_o = head_q;
	assign frame_done_o = done_q;
	assign sclk_fall_o = fall[0] & ~filt_q[2];

endmodule : serial_frame_rx

// [design/synth_top_control_regs.sv]
// Top-level control registers: device reset, power-down, calibration clock and amplitude settle delay
//
// Summary of operation
// - Writing one to the reset bit resets the device; the bit self-clears, reads zero.
// - Power-down bit at one stops the calibration clock and settle timer, serial access stays up; zero runs them.
// - Calibration clock is the reference input divided by two to the exponent field.
// - Eight-bit settle delay field sets the amplitude calibration wait, default 25.
`timescale 1ns/10ps
module synth_top_control_regs
	import synth_ctrl_pkg::*;
#(
	parameter logic [15:0] MAIN_CTRL_RESET = RST_MAIN_CTRL,
	parameter logic [15:0] CAL_CLK_RESET = RST_CAL_CLK,
	parameter logic [15:0] RSVD_TWO_RESET = RST_RSVD_TWO,
	parameter logic [15:0] ACAL_TIMING_RESET = RST_ACAL_TIMING,
	parameter logic [15:0] RSVD_SEVEN_RESET = RST_RSVD_SEVEN
)
(
	// Clock (the reference input) and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// Serial interface pins
	input wire logic sclk_i,
	input wire logic sdi_i,
	input wire logic cs_n_i,
	output logic muxout_o,
	// Lock indication fed to the multiplexed output
	input wire logic lock_detect_i,
	// Amplitude calibration settle timer
	input wire logic acal_start_i,
	output logic acal_settle_busy_o,
	output logic acal_settle_done_o,
	// Device control
	output ctrl_cfg_s ctrl_cfg_o,
	output logic device_reset_o,
	output logic cal_clk_en_o
);

	frame_s frame;
	logic head_valid;
	logic frame_done;
	logic sclk_fall;

	logic [15:0] main_ctrl_q;
	logic [15:0] cal_clk_q;
	logic [15:0] rsvd_two_q;
	logic [15:0] acal_timing_q;
	logic [15:0] rsvd_seven_q;
	logic soft_reset_q;
	logic wr_main;
	logic wr_cal;
	logic wr_two;
	logic wr_acal;
	logic wr_seven;
	logic [15:0] rd_word;
	logic [15:0] rd_shift_q;
	logic rd_first_q;
	logic muxout_q;
	logic [6:0] div_cnt_q;
	logic [6:0] div_mask;
	logic cal_tick_q;
	logic [7:0] settle_cnt_q;
	logic settle_busy_q;
	logic settle_done_q;

	serial_frame_rx u_rx (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.sclk_i(sclk_i),
		.sdi_i(sdi_i),
		.cs_n_i(cs_n_i),
		.frame_o(frame),
		.head_valid_o(head_valid),
		.frame_done_o(frame_done),
		.sclk_fall_o(sclk_fall)
	);

	// Write decode: a frame commits only when complete and marked as a write
	assign wr_main = frame_done && !frame.rd && frame.addr == ADDR_MAIN_CTRL;
	assign wr_cal = frame_done && !frame.rd && frame.addr == ADDR_CAL_CLK;
	assign wr_two = frame_done && !frame.rd && frame.addr == ADDR_RSVD_TWO;
	assign wr_acal = frame_done && !frame.rd && frame.addr == ADDR_ACAL_TIMING;
	assign wr_seven = frame_done && !frame.rd && frame.addr == ADDR_RSVD_SEVEN;

	// Reset command pulse; the stored bit never holds a one
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			soft_reset_q <= 1'b0;
		else
			soft_reset_q <= wr_main && frame.data[BIT_RESET_CMD];
	end

	// Main control word: power-down and other control bits
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			main_ctrl_q <= MAIN_CTRL_RESET;
		else if (soft_reset_q)
			main_ctrl_q <= MAIN_CTRL_RESET;
		else if (wr_main)
		begin
			main_ctrl_q <= frame.data;
			main_ctrl_q[BIT_RESET_CMD] <= 1'b0;
		end
	end

	// Calibration clock divider exponent word
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			cal_clk_q <= CAL_CLK_RESET;
		else if (soft_reset_q)
			cal_clk_q <= CAL_CLK_RESET;
		else if (wr_cal)
			cal_clk_q <= frame.data;
	end

	// Amplitude calibration timing word
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			acal_timing_q <= ACAL_TIMING_RESET;
		else if (soft_reset_q)
			acal_timing_q <= ACAL_TIMING_RESET;
		else if (wr_acal)
			acal_timing_q <= frame.data;
	end

	// Reserved words are stored as written so the host pattern reads back
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rsvd_two_q <= RSVD_TWO_RESET;
			rsvd_seven_q <= RSVD_SEVEN_RESET;
		end
		else if (soft_reset_q)
		begin
			rsvd_two_q <= RSVD_TWO_RESET;
			rsvd_seven_q <= RSVD_SEVEN_RESET;
		end
		else
		begin
			if (wr_two)
				rsvd_two_q <= frame.data;
			if (wr_seven)
				rsvd_seven_q <= frame.data;
		end
	end

	// Readback word selection
	always_comb
	begin
		unique case (frame.addr)
			ADDR_MAIN_CTRL: rd_word = main_ctrl_q;
			ADDR_CAL_CLK: rd_word = cal_clk_q;
			ADDR_RSVD_TWO: rd_word = rsvd_two_q;
			ADDR_ACAL_TIMING: rd_word = acal_timing_q;
			ADDR_RSVD_SEVEN: rd_word = rsvd_seven_q;
			default: rd_word = 16'h0000;
		endcase
	end

	// Read data loads after the header and shifts out MSB first on sclk falling edges
	// The falling edge that closes the header is skipped so bit 15 stands for the first data rising edge
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rd_shift_q <= 16'h0000;
			rd_first_q <= 1'b0;
		end
		else if (head_valid && frame.rd)
		begin
			rd_shift_q <= rd_word;
			rd_first_q <= 1'b1;
		end
		else if (sclk_fall && rd_first_q)
			rd_first_q <= 1'b0;
		else if (sclk_fall)
			rd_shift_q <= {rd_shift_q[14:0], 1'b0};
	end

	// Multiplexed output: lock indication or serial readback
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			muxout_q <= 1'b0;
		else if (main_ctrl_q[BIT_MUXOUT_SEL])
			muxout_q <= lock_detect_i & main_ctrl_q[BIT_LD_EN];
		else
			muxout_q <= rd_shift_q[15];
	end

	// Calibration clock enable: one pulse every 2^exponent reference cycles
	assign div_mask = 7'((8'h01 << cal_clk_q[CAL_DIV_LSB +: CAL_DIV_W]) - 8'h01);

	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			div_cnt_q <= 7'h00;
			cal_tick_q <= 1'b0;
		end
		else if (main_ctrl_q[BIT_POWERDOWN] || soft_reset_q)
		begin
			div_cnt_q <= 7'h00;
			cal_tick_q <= 1'b0;
		end
		else
		begin
			cal_tick_q <= ((div_cnt_q & div_mask) == div_mask);
			div_cnt_q <= ((div_cnt_q & div_mask) == div_mask) ? 7'h00 : div_cnt_q + 7'h01;
		end
	end

	// Amplitude settle timer counts calibration clock ticks of the programmed delay
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			settle_cnt_q <= 8'h00;
			settle_busy_q <= 1'b0;
			settle_done_q <= 1'b0;
		end
		else if (main_ctrl_q[BIT_POWERDOWN] || soft_reset_q)
		begin
			settle_cnt_q <= 8'h00;
			settle_busy_q <= 1'b0;
			settle_done_q <= 1'b0;
		end
		else if (acal_start_i && !settle_busy_q)
		begin
			settle_cnt_q <= acal_timing_q[SETTLE_LSB +: SETTLE_W];
			settle_busy_q <= 1'b1;
			settle_done_q <= 1'b0;
		end
		else if (settle_busy_q && settle_cnt_q == 8'h00)
		begin
			settle_busy_q <= 1'b0;
			settle_done_q <= 1'b1;
		end
		else
		begin
			settle_done_q <= 1'b0;
			if (settle_busy_q && cal_tick_q)
				settle_cnt_q <= settle_cnt_q - 8'h01;
		end
	end

	assign ctrl_cfg_o.powerdown = main_ctrl_q[BIT_POWERDOWN];
	assign ctrl_cfg_o.muxout_sel = main_ctrl_q[BIT_MUXOUT_SEL];
	assign ctrl_cfg_o.lock_detect_en = main_ctrl_q[BIT_LD_EN];
	assign ctrl_cfg_o.cal_clk_div = cal_clk_q[CAL_DIV_LSB +: CAL_DIV_W];
	assign ctrl_cfg_o.amplitude_cal_settle_delay = acal_timing_q[SETTLE_LSB +: SETTLE_W];
	assign device_reset_o = soft_reset_q;
	assign cal_clk_en_o = cal_tick_q;
	assign muxout_o = muxout_q;
	assign acal_settle_busy_o = settle_busy_q;
	assign acal_settle_done_o = settle_done_q;

endmodule : synth_top_control_regs

// [verification/synth_ctrl_sva.sv]
// Port assertions for the top-level control register block
`timescale 1ns/10ps
module synth_ctrl_sva
	import synth_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// Watched inputs
	input wire logic acal_start_i,
	// Watched outputs
	input wire logic acal_settle_busy_o,
	input wire logic acal_settle_done_o,
	input wire ctrl_cfg_s ctrl_cfg_o,
	input wire logic device_reset_o,
	input wire logic cal_clk_en_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	logic [7:0] gap_q;
	logic seen_q;
	logic [2:0] div_q;
	logic go;
	assign go = acal_start_i && !acal_settle_busy_o && !ctrl_cfg_o.powerdown && !device_reset_o;
	// Tick spacing is only judged once a tick came under an unchanged divider
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			gap_q <= 8'h00;
			seen_q <= 1'b0;
			div_q <= 3'h3;
		end
		else
		begin
			gap_q <= cal_clk_en_o ? 8'h01 : gap_q + 8'h01;
			seen_q <= (seen_q || cal_clk_en_o) && !device_reset_o && !ctrl_cfg_o.powerdown
				&& ctrl_cfg_o.cal_clk_div == div_q;
			div_q <= ctrl_cfg_o.cal_clk_div;
		end
	end
	a_tick_spacing_exact:
		assert property (seen_q |-> (cal_clk_en_o ? {1'b0, gap_q} == (9'h001 << div_q)
			: {1'b0, gap_q} < (9'h001 << div_q))) else $error("calibration tick spacing wrong");
	a_reset_cmd_pulse:
		assert property (device_reset_o |=> !device_reset_o) else $error("reset command pulse too long");
	a_reset_to_defaults:
		assert property (device_reset_o |=> ctrl_cfg_o.cal_clk_div == 3'h3
			&& ctrl_cfg_o.amplitude_cal_settle_delay == 8'h19 && !ctrl_cfg_o.powerdown) else $error("fields not at defaults");
	a_pd_no_tick:
		assert property (ctrl_cfg_o.powerdown && $past(ctrl_cfg_o.powerdown) |-> !cal_clk_en_o) else $error("tick while down");
	a_pd_no_busy:
		assert property (ctrl_cfg_o.powerdown [*2] |-> !acal_settle_busy_o) else $error("settle timer runs while down");
	a_start_gives_busy:
		assert property (go |=> acal_settle_busy_o) else $error("accepted start without busy");
	a_done_ends_busy:
		assert property (acal_settle_done_o |-> $past(acal_settle_busy_o) && !acal_settle_busy_o ##1 !acal_settle_done_o)
			else $error("done pulse out of place");
	a_zero_delay_done:
		assert property (go && ctrl_cfg_o.amplitude_cal_settle_delay == 8'h00 |-> ##2 acal_settle_done_o)
			else $error("zero delay done late");
endmodule : synth_ctrl_sva

bind synth_top_control_regs synth_ctrl_sva u_sva (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .acal_start_i(acal_start_i),
	.acal_settle_busy_o(acal_settle_busy_o), .acal_settle_done_o(acal_settle_done_o), .ctrl_cfg_o(ctrl_cfg_o),
	.device_reset_o(device_reset_o), .cal_clk_en_o(cal_clk_en_o));

// [verification/serial_host_model.sv]
// Host model that drives serial write and read frames
`timescale 1ns/10ps
module serial_host_model
	import synth_ctrl_pkg::*;
(
	// Clock
	input wire logic clk_i,
	// Serial pins
	output logic sclk_o,
	output logic sdi_o,
	output logic cs_n_o,
	input wire logic muxout_i
);
	initial
	begin
		sclk_o = 1'b0;
		sdi_o = 1'b0;
		cs_n_o = 1'b1;
	end
	// Each serial clock phase lasts eight system clocks
	task automatic xfer(input frame_s f, output logic [15:0] q);
		logic [23:0] w;
		w = f;
		q = 16'h0000;
		if (!f.rd)
			case (f.addr)
				ADDR_CAL_CLK: w[15:3] = RST_CAL_CLK[15:3];
				ADDR_ACAL_TIMING: w[7:0] = RST_ACAL_TIMING[7:0];
				ADDR_RSVD_TWO: w[15:0] = RST_RSVD_TWO;
				ADDR_RSVD_SEVEN: w[15:0] = RST_RSVD_SEVEN;
				default: ;
			endcase
		@(negedge clk_i);
		cs_n_o = 1'b0;
		for (int i = 23; i >= 0; i--)
		begin
			sdi_o = w[i];
			repeat (8) @(negedge clk_i);
			sclk_o = 1'b1;
			if (i < 16)
				q[i] = muxout_i;
			repeat (8) @(negedge clk_i);
			sclk_o = 1'b0;
		end
		repeat (8) @(negedge clk_i);
		cs_n_o = 1'b1;
		// A released data line does not keep its last level
		sdi_o = ~sdi_o;
		repeat (8) @(negedge clk_i);
	endtask : xfer
endmodule : serial_host_model

// [verification/testbench.sv]
// Self-checking bench for the top-level control register block
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %s expected %h seen %h", n, e, g); end end
module testbench
	import synth_ctrl_pkg::*;
;
	logic clk;
	logic nrst;
	logic sclk;
	logic sdi;
	logic cs_n;
	logic muxout;
	logic lock;
	logic start;
	logic busy;
	logic done;
	ctrl_cfg_s cfg;
	logic dev_rst;
	logic tick;
	int fail_count;
	int samples_checked;
	int rst_seen;
	int n;
	string name_q[$];
	logic [15:0] exp_q[$];
	logic [15:0] got_q[$];
	string sn;
	logic [15:0] se;
	logic [15:0] sg;
	logic [2:0] dv;
	logic [7:0] dl;
	synth_top_control_regs DUT (.sys_clk_i(clk), .nrst_i(nrst), .sclk_i(sclk), .sdi_i(sdi), .cs_n_i(cs_n),
		.muxout_o(muxout), .lock_detect_i(lock), .acal_start_i(start), .acal_settle_busy_o(busy),
		.acal_settle_done_o(done), .ctrl_cfg_o(cfg), .device_reset_o(dev_rst), .cal_clk_en_o(tick));
	serial_host_model host (.clk_i(clk), .sclk_o(sclk), .sdi_o(sdi), .cs_n_o(cs_n), .muxout_i(muxout));
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(negedge clk) if (dev_rst === 1'b1) rst_seen++;
	initial
	forever
	begin
		wait (got_q.size() > 0);
		sn = name_q.pop_front();
		se = exp_q.pop_front();
		sg = got_q.pop_front();
		`CHK(sn, se, sg)
	end
	task automatic note(input string s, input logic [15:0] e, input logic [15:0] g);
		name_q.push_back(s);
		exp_q.push_back(e);
		got_q.push_back(g);
	endtask : note
	task automatic results;
		repeat (2) @(negedge clk);
		$display("checks %0d errors %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		logic [15:0] q;
		host.xfer({1'b0, a, d}, q);
	endtask : wr
	task automatic rdchk(input string s, input logic [6:0] a, input logic [15:0] e);
		logic [15:0] q;
		host.xfer({1'b1, a, 16'h0000}, q);
		note(s, e, q);
	endtask : rdchk
	task automatic hang(input string s);
		fail_count++;
		$display("[ERR] %s expected event seen none", s);
		results();
	endtask : hang
	task automatic gap(output int c);
		c = 0;
		do @(negedge clk); while (tick !== 1'b1 && ++c < 300);
		c = 0;
		do begin @(negedge clk); c++; end while (tick !== 1'b1 && c < 300);
		if (c >= 300) hang("tick");
	endtask : gap
	task automatic settle(output int c);
		@(negedge clk);
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		c = 1;
		while (done !== 1'b1 && c < 2000) begin @(negedge clk); c++; end
		if (c >= 2000) hang("settle done");
	endtask : settle
	initial
	begin
		nrst = 1'b0;
		lock = 1'b0;
		start = 1'b0;
		n = $urandom(32'h02f9);
		repeat (10) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		note("div", 16'h0003, {13'h0, cfg.cal_clk_div});
		note("delay", 16'h0019, {8'h0, cfg.amplitude_cal_settle_delay});
		wr(ADDR_MAIN_CTRL, 16'h2018);
		rdchk("main", ADDR_MAIN_CTRL, 16'h2018);
		rdchk("unmapped", 7'h03, 16'h0000);
		repeat (3)
		begin
			dv = 3'($urandom);
			dl = 8'($urandom);
			wr(ADDR_CAL_CLK, {13'($urandom), dv});
			wr(ADDR_ACAL_TIMING, {dl, 8'($urandom)});
			wr(ADDR_RSVD_SEVEN, 16'($urandom));
			rdchk("cal clk", ADDR_CAL_CLK, {RST_CAL_CLK[15:3], dv});
			rdchk("acal", ADDR_ACAL_TIMING, {dl, RST_ACAL_TIMING[7:0]});
			rdchk("rsvd seven", ADDR_RSVD_SEVEN, RST_RSVD_SEVEN);
			gap(n);
			note("tick gap", 16'h0001 << dv, 16'(n));
		end
		wr(ADDR_CAL_CLK, 16'h0000);
		for (int i = 0; i < 3; i++)
		begin
			dl = 8'(i * 20);
			wr(ADDR_ACAL_TIMING, {dl, 8'h00});
			settle(n);
			note("settle", 16'h0001, {15'h0, n >= dl && n <= dl + 3});
		end
		wr(ADDR_MAIN_CTRL, 16'h2019);
		rdchk("main pd", ADDR_MAIN_CTRL, 16'h2019);
		note("pd flag", 16'h0001, {15'h0, cfg.powerdown});
		n = 0;
		start = 1'b1;
		repeat (200) begin @(negedge clk); start = 1'b0; n += (tick === 1'b1 || busy === 1'b1); end
		note("down activity", 16'h0000, 16'(n));
		wr(ADDR_MAIN_CTRL, 16'h2018);
		gap(n);
		note("up tick gap", 16'h0001, 16'(n));
		wr(ADDR_CAL_CLK, 16'h0005);
		rst_seen = 0;
		wr(ADDR_MAIN_CTRL, 16'h201a);
		lock = 1'b1;
		repeat (4) @(negedge clk);
		note("reset pulses", 16'h0001, 16'(rst_seen));
		note("div reset", 16'h0003, {13'h0, cfg.cal_clk_div});
		note("lock out", 16'h0001, {15'h0, muxout});
		wr(ADDR_MAIN_CTRL, 16'h2018);
		rdchk("main", ADDR_MAIN_CTRL, 16'h2018);
		rdchk("cal clk", ADDR_CAL_CLK, RST_CAL_CLK);
		results();
	end
endmodule : testbench
